// >>> src/psc_pkg.sv
// shared constants and state types for the passive serial chain loader
// assumes a 10 MHz core clock on the host end; the device end runs on the link clock

package psc_pkg;

  // ---------------------------------------------------------------
  // core clock and link timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 100;
  // least low time of the request line that the host produces
  localparam int REQ_LOW_NS = 2000;
  // least time rounds up to whole core cycles
  localparam int REQ_LOW_CYCLES = (REQ_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // core cycles per half period of the serial clock the host makes
  localparam int SCLK_HALF = 8;
  // falling serial clock edges needed after completion before user mode
  localparam int INIT_FALL_EDGES = 2;

  // ---------------------------------------------------------------
  // data layout
  // ---------------------------------------------------------------
  localparam int BYTE_W = 8;
  // bits of image each device takes; last bit makes parity even
  localparam int IMAGE_BITS = 256;

  // ---------------------------------------------------------------
  // state types
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    PSC_DEV_START,
    PSC_DEV_WAIT_EN,
    PSC_DEV_LOAD,
    PSC_DEV_RELEASED,
    PSC_DEV_INIT,
    PSC_DEV_USER,
    PSC_DEV_HALT,
    PSC_DEV_FAULT
  } psc_dev_state_t;

  typedef enum logic [2:0] {
    PSC_HOST_IDLE,
    PSC_HOST_REQ,
    PSC_HOST_WAIT,
    PSC_HOST_SEND,
    PSC_HOST_FLUSH,
    PSC_HOST_DONE,
    PSC_HOST_ERR
  } psc_host_state_t;

endpackage

// >>> src/psc_link_if.sv
// link between one loader host and one chained device
// assumes the bench drives the ext lines for the rest of the chain (high when absent)
`timescale 1ns/10ps

interface psc_link_if;
  // host driven lines
  logic config_request_n;
  logic config_serial_clock;
  logic config_data;
  logic user_startup_clock;
  // chain enable in and out of this device
  logic config_enable_in_n;
  logic chain_enable_out_n;
  // open-drain drivers of this device, enable low while driving
  logic status_o;
  logic status_oe_n;
  logic complete_o;
  logic complete_oe_n;
  // wired contributions of other devices on the same lines
  logic status_ext_n;
  logic complete_ext;
  // resolved wired-and levels with pull-up
  logic config_status_n;
  logic config_complete;

  // ---------------------------------------------------------------
  // wired-and resolution
  // ---------------------------------------------------------------
  assign config_status_n = status_ext_n & (status_oe_n | status_o);
  assign config_complete = complete_ext & (complete_oe_n | complete_o);

  modport device (
    input config_request_n, config_serial_clock, config_data, user_startup_clock,
    input config_enable_in_n, config_status_n, config_complete,
    output chain_enable_out_n, status_o, status_oe_n, complete_o, complete_oe_n
  );

  modport host (
    output config_request_n, config_serial_clock, config_data, user_startup_clock,
    input config_status_n, config_complete
  );
endinterface

// >>> src/psc_sync.sv
// two flip-flop level synchroniser, W bits wide
// assumes each bit is a level from a flop of another domain
`timescale 1ns/10ps

module psc_sync #(
  parameter int W = 1
) (
  // clock and reset of the receiving domain
  input wire logic i_clk,
  input wire logic i_rst,
  // level in and synchronised level out
  input wire logic [W-1:0] i_d,
  output logic [W-1:0] o_q
);
  logic [W-1:0] meta;

  // ---------------------------------------------------------------
  // capture chain; meta is read by the second stage only
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      meta <= '0;
      o_q <= '0;
    end else begin
      meta <= i_d;
      o_q <= meta;
    end
  end
endmodule

// >>> src/psc_device.sv
// chained passive serial device end: takes its slice of the shared bitstream
// assumes the link clock comes from the host and runs while a request is pending
`timescale 1ns/10ps

module psc_device #(
  parameter int IMAGE_BITS = psc_pkg::IMAGE_BITS
) (
  // core clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst,
  // state seen from the core side
  output logic o_loaded,
  output logic o_user_mode,
  output logic o_error,
  // link to the host and chain neighbours
  psc_link_if.device link
);
  localparam int CW = $clog2(IMAGE_BITS + 1);
  localparam logic [CW-1:0] LAST_BIT = CW'(IMAGE_BITS - 1);
  localparam logic [1:0] LAST_FALL = 2'(psc_pkg::INIT_FALL_EDGES - 1);

  // ---------------------------------------------------------------
  // link reset: core reset or request line low
  // ---------------------------------------------------------------
  logic link_rst;
  logic rst_meta;
  logic rst_hold;

  assign link_rst = i_rst | ~link.config_request_n;

  // release is synchronised to the link clock, assert is immediate
  always_ff @(posedge link.config_serial_clock or posedge link_rst) begin
    if (link_rst) begin
      rst_meta <= 1'b1;
      rst_hold <= 1'b1;
    end else begin
      rst_meta <= 1'b0;
      rst_hold <= rst_meta;
    end
  end

  // ---------------------------------------------------------------
  // link side state
  // ---------------------------------------------------------------
  psc_pkg::psc_dev_state_t state;
  psc_pkg::psc_dev_state_t next_state;
  logic [CW-1:0] count;
  logic [CW-1:0] next_count;
  logic parity;
  logic next_parity;
  logic [1:0] falls;
  logic [1:0] next_falls;
  logic chain_n;
  logic next_chain_n;
  logic status_oe_n;
  logic next_status_oe_n;
  logic complete_oe_n;
  logic next_complete_oe_n;
  logic [2:0] flags;
  logic [2:0] next_flags;

  // next state of the loader
  always_comb begin
    next_state = state;
    next_count = count;
    next_parity = parity;
    next_falls = falls;
    next_chain_n = chain_n;
    next_status_oe_n = status_oe_n;
    next_complete_oe_n = complete_oe_n;
    if (rst_hold) begin
      // held in reset: status low, completion low, chain off
      next_state = psc_pkg::PSC_DEV_START;
      next_count = '0;
      next_parity = 1'b0;
      next_falls = '0;
      next_chain_n = 1'b1;
      next_status_oe_n = 1'b0;
      next_complete_oe_n = 1'b0;
    end else begin
      unique case (state)
        psc_pkg::PSC_DEV_START: begin
          // release status; its own low level is not read this cycle
          next_state = psc_pkg::PSC_DEV_WAIT_EN;
          next_status_oe_n = 1'b1;
        end
        psc_pkg::PSC_DEV_WAIT_EN, psc_pkg::PSC_DEV_LOAD: begin
          if (!link.config_status_n) begin
            next_state = psc_pkg::PSC_DEV_HALT;
          end else if (!link.config_enable_in_n) begin
            // taken on this rising edge, even the first after enable
            next_state = psc_pkg::PSC_DEV_LOAD;
            next_parity = parity ^ link.config_data;
            next_count = count + 1'b1;
            if (count == LAST_BIT) begin
              if (next_parity) begin
                // parity broken: pull status low for the whole chain
                next_state = psc_pkg::PSC_DEV_FAULT;
                next_status_oe_n = 1'b0;
              end else begin
                next_state = psc_pkg::PSC_DEV_RELEASED;
                next_chain_n = 1'b0;
                next_complete_oe_n = 1'b1;
              end
            end
          end
          // enable high: data and clock activity is ignored
        end
        psc_pkg::PSC_DEV_RELEASED: begin
          if (!link.config_status_n) begin
            next_state = psc_pkg::PSC_DEV_HALT;
          end else if (link.config_complete) begin
            // wired line high means every device has finished
            next_state = psc_pkg::PSC_DEV_INIT;
            next_falls = '0;
          end
        end
        psc_pkg::PSC_DEV_INIT: begin
          // each rising edge here follows one falling edge
          if (!link.config_status_n) begin
            next_state = psc_pkg::PSC_DEV_HALT;
          end else if (falls == LAST_FALL) begin
            // no user startup clock is waited
            next_state = psc_pkg::PSC_DEV_USER;
          end else begin
            next_falls = falls + 1'b1;
          end
        end
        psc_pkg::PSC_DEV_USER, psc_pkg::PSC_DEV_HALT, psc_pkg::PSC_DEV_FAULT: begin
          // only a new request or a core reset leaves these
          next_state = state;
        end
      endcase
    end
    // flags registered so the crossing sees clean flop outputs
    next_flags = {next_state == psc_pkg::PSC_DEV_FAULT,
                  next_state == psc_pkg::PSC_DEV_USER,
                  ~next_chain_n};
  end

  // link side registers
  always_ff @(posedge link.config_serial_clock or posedge link_rst) begin
    if (link_rst) begin
      state <= psc_pkg::PSC_DEV_START;
      count <= '0;
      parity <= 1'b0;
      falls <= '0;
      chain_n <= 1'b1;
      status_oe_n <= 1'b0;
      complete_oe_n <= 1'b0;
      flags <= '0;
    end else begin
      state <= next_state;
      count <= next_count;
      parity <= next_parity;
      falls <= next_falls;
      chain_n <= next_chain_n;
      status_oe_n <= next_status_oe_n;
      complete_oe_n <= next_complete_oe_n;
      flags <= next_flags;
    end
  end

  // ---------------------------------------------------------------
  // pin drivers
  // ---------------------------------------------------------------
  // open-drain lines only ever pull low; release lets the pull-up win
  assign link.status_o = 1'b0;
  assign link.complete_o = 1'b0;
  assign link.status_oe_n = status_oe_n;
  assign link.complete_oe_n = complete_oe_n;
  assign link.chain_enable_out_n = chain_n;

  // ---------------------------------------------------------------
  // crossing to the core domain
  // ---------------------------------------------------------------
  // link clock may stop after the frame; the levels just hold
  logic [2:0] core_flags;

  psc_sync #(
    .W(3)
  ) u_flag_sync (
    .i_clk(i_core_clk),
    .i_rst(i_rst),
    .i_d(flags),
    .o_q(core_flags)
  );

  assign o_error = core_flags[2];
  assign o_user_mode = core_flags[1];
  assign o_loaded = core_flags[0];
endmodule

// >>> src/psc_host.sv
// loader host end: makes the serial clock, streams bytes least bit first
// assumes a byte source with valid/ready on the core clock
`timescale 1ns/10ps

module psc_host #(
  parameter int SCLK_HALF = psc_pkg::SCLK_HALF
) (
  // core clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst,
  // attempt control
  input wire logic i_start,
  output logic o_busy,
  output logic o_done,
  output logic o_error,
  // byte stream in
  input wire logic i_byte_valid,
  input wire logic [psc_pkg::BYTE_W-1:0] i_byte,
  output logic o_byte_ready,
  // link to the chain
  psc_link_if.host link
);
  localparam int DW = $clog2(SCLK_HALF + 1);
  localparam logic [DW-1:0] DIV_LAST = DW'(SCLK_HALF - 1);
  localparam int RW = $clog2(psc_pkg::REQ_LOW_CYCLES + 1);
  localparam logic [RW-1:0] REQ_LAST = RW'(psc_pkg::REQ_LOW_CYCLES - 1);
  // the device sees a fall only at the rise after it, so one rise more is owed
  localparam logic [1:0] FLUSH_RISES = 2'(psc_pkg::INIT_FALL_EDGES + 1);
  localparam logic [2:0] LAST_IDX = 3'(psc_pkg::BYTE_W - 1);

  // ---------------------------------------------------------------
  // wired lines into the core domain
  // ---------------------------------------------------------------
  logic [1:0] pins_s;

  psc_sync #(
    .W(2)
  ) u_pin_sync (
    .i_clk(i_core_clk),
    .i_rst(i_rst),
    .i_d({link.config_status_n, link.config_complete}),
    .o_q(pins_s)
  );

  // ---------------------------------------------------------------
  // sequencer, clock divider and shifter
  // ---------------------------------------------------------------
  psc_pkg::psc_host_state_t state, next_state;
  logic [DW-1:0] div, next_div;
  logic [RW-1:0] req_cnt, next_req_cnt;
  logic sclk, next_sclk;
  logic sdata, next_sdata;
  logic [psc_pkg::BYTE_W-1:0] sh, next_sh;
  logic [2:0] idx, next_idx;
  logic have, next_have;
  logic [1:0] falls, next_falls;
  logic req_n, next_req_n;
  logic ready, next_ready;
  logic busy, next_busy;
  logic done, next_done;
  logic err, next_err;
  logic tick;
  logic fall;
  logic rise_ok;

  always_comb begin
    next_state = state;
    next_req_cnt = req_cnt;
    next_sdata = sdata;
    next_sh = sh;
    next_idx = idx;
    next_have = have;
    next_falls = falls;
    next_req_n = req_n;
    next_busy = busy;
    next_done = done;
    next_err = err;
    tick = (div == DIV_LAST);
    next_div = tick ? '0 : div + 1'b1;
    fall = tick & sclk;
    // in send a rise only starts with a bit in hand, so stalls keep the clock low
    rise_ok = (state == psc_pkg::PSC_HOST_REQ) || (state == psc_pkg::PSC_HOST_WAIT) ||
              (state == psc_pkg::PSC_HOST_FLUSH) || (state == psc_pkg::PSC_HOST_SEND && have);
    next_sclk = sclk;
    if (tick) begin
      next_sclk = sclk ? 1'b0 : rise_ok;
    end
    unique case (state)
      psc_pkg::PSC_HOST_IDLE, psc_pkg::PSC_HOST_DONE, psc_pkg::PSC_HOST_ERR: begin
        // restart is only ever by a fresh start, for the whole chain
        if (i_start) begin
          next_state = psc_pkg::PSC_HOST_REQ;
          next_req_n = 1'b0;
          next_req_cnt = '0;
          next_busy = 1'b1;
          next_done = 1'b0;
          next_err = 1'b0;
          next_have = 1'b0;
        end
      end
      psc_pkg::PSC_HOST_REQ: begin
        next_req_cnt = req_cnt + 1'b1;
        if (req_cnt == REQ_LAST) begin
          next_state = psc_pkg::PSC_HOST_WAIT;
          next_req_n = 1'b1;
        end
      end
      psc_pkg::PSC_HOST_WAIT: begin
        // data only once status is released
        if (pins_s[1]) begin
          next_state = psc_pkg::PSC_HOST_SEND;
        end
      end
      psc_pkg::PSC_HOST_SEND: begin
        if (!pins_s[1]) begin
          next_state = psc_pkg::PSC_HOST_ERR;
        end else if (pins_s[0]) begin
          // keep clocking bits until completion is seen
          next_state = psc_pkg::PSC_HOST_FLUSH;
          next_falls = '0;
        end else if (!have && i_byte_valid && ready) begin
          // one stream for the chain, no addressing
          next_sh = i_byte;
          next_sdata = i_byte[0];
          next_idx = '0;
          next_have = 1'b1;
        end else if (fall && have) begin
          // data changes on the falling edge, ahead of the device's rise
          if (idx == LAST_IDX) begin
            next_have = 1'b0;
          end else begin
            next_idx = idx + 1'b1;
            next_sh = {1'b0, sh[psc_pkg::BYTE_W-1:1]};
            next_sdata = sh[1];
          end
        end
      end
      psc_pkg::PSC_HOST_FLUSH: begin
        // count rises: the first one here may be the one that shows completion,
        // so the run ends on the fall after the third rise, two falls seen
        if (!pins_s[1]) begin
          next_state = psc_pkg::PSC_HOST_ERR;
        end else if (tick && !sclk) begin
          next_falls = falls + 1'b1;
        end else if (fall && falls == FLUSH_RISES) begin
          next_state = psc_pkg::PSC_HOST_DONE;
        end
      end
      default: begin
        // illegal code falls back to idle
        next_state = psc_pkg::PSC_HOST_IDLE;
      end
    endcase
    if (next_state == psc_pkg::PSC_HOST_DONE) begin
      next_busy = 1'b0;
      next_done = 1'b1;
    end
    if (next_state == psc_pkg::PSC_HOST_ERR) begin
      next_busy = 1'b0;
      next_err = 1'b1;
    end
    next_ready = (next_state == psc_pkg::PSC_HOST_SEND) && !next_have;
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      state <= psc_pkg::PSC_HOST_IDLE;
      div <= '0;
      req_cnt <= '0;
      sclk <= 1'b0;
      sdata <= 1'b0;
      sh <= '0;
      idx <= '0;
      have <= 1'b0;
      falls <= '0;
      req_n <= 1'b1;
      ready <= 1'b0;
      busy <= 1'b0;
      done <= 1'b0;
      err <= 1'b0;
    end else begin
      state <= next_state;
      div <= next_div;
      req_cnt <= next_req_cnt;
      sclk <= next_sclk;
      sdata <= next_sdata;
      sh <= next_sh;
      idx <= next_idx;
      have <= next_have;
      falls <= next_falls;
      req_n <= next_req_n;
      ready <= next_ready;
      busy <= next_busy;
      done <= next_done;
      err <= next_err;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign link.config_request_n = req_n;
  assign link.config_serial_clock = sclk;
  assign link.config_data = sdata;
  assign link.user_startup_clock = 1'b0;
  assign o_byte_ready = ready;
  assign o_busy = busy;
  assign o_done = done;
  assign o_error = err;
endmodule

// >>> tb/psc_link_properties.sv
// link-side properties of the chained serial loader
// assumes it watches the one psc_link_if; a low request line acts as reset
`timescale 1ns/10ps

module psc_link_properties (
  // host driven lines
  input wire logic config_request_n,
  input wire logic config_serial_clock,
  input wire logic user_startup_clock,
  // chain and wired lines
  input wire logic config_enable_in_n,
  input wire logic chain_enable_out_n,
  input wire logic status_oe_n,
  input wire logic complete_oe_n,
  input wire logic status_ext_n,
  input wire logic config_status_n
);
  // ---------------------------------------------------------------
  // all checks sit on the serial clock rising edge
  // ---------------------------------------------------------------
  default clocking cb @(posedge config_serial_clock); endclocking
  default disable iff (!config_request_n);

  // own image accepted, own fault raised
  sequence s_own_done;
    $rose(complete_oe_n);
  endsequence
  sequence s_own_fault;
    $fell(status_oe_n);
  endsequence

  a_chain_off_disabled: assert property (config_enable_in_n |-> chain_enable_out_n)
    else $error("chain enable low while device disabled");
  a_chain_needs_enable: assert property ($fell(chain_enable_out_n) |-> !config_enable_in_n)
    else $error("chain enable fell without own enable");
  a_done_opens_chain: assert property (s_own_done |-> !chain_enable_out_n)
    else $error("completion released but chain enable high");
  a_chain_stands: assert property (!chain_enable_out_n |=> !chain_enable_out_n)
    else $error("chain enable dropped before new request");
  a_done_stands: assert property (s_own_done |=> complete_oe_n [*2])
    else $error("completion release did not stand");
  a_fault_holds_done: assert property (s_own_fault |-> !complete_oe_n)
    else $error("completion released together with fault");
  a_fault_pulls_status: assert property (s_own_fault |-> !config_status_n)
    else $error("fault did not pull status line low");
  a_halt_no_drive: assert property ((!status_ext_n && status_oe_n) |=> status_oe_n)
    else $error("device drove status on an external halt");
  a_done_needs_status: assert property (s_own_done |-> config_status_n)
    else $error("completion released while status low");
  a_startup_idle: assert property (!user_startup_clock)
    else $error("user startup clock toggled");
endmodule

// >>> tb/tb_ps_chain_config_loader.sv
// self-checking bench: host end and device end joined by one link
// assumes the bench stands in for the rest of the chain on the wired lines
`timescale 1ns/10ps

module tb_ps_chain_config_loader;
  // ---------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------
  localparam int IMG = 16;
  logic clk;
  logic rst;
  logic i_start;
  logic i_byte_valid;
  logic [psc_pkg::BYTE_W-1:0] i_byte;
  logic h_busy, h_done, h_err, h_ready, d_loaded, d_user, d_err;
  int error_cnt;
  int cmp_count;
  int cyc;
  int cap_left;
  logic bits[$];

  psc_link_if link();

  psc_host #(.SCLK_HALF(2)) psc_host_inst (.i_core_clk(clk), .i_rst(rst), .i_start(i_start), .o_busy(h_busy),
    .o_done(h_done), .o_error(h_err), .i_byte_valid(i_byte_valid), .i_byte(i_byte), .o_byte_ready(h_ready),
    .link(link.host));
  psc_device #(.IMAGE_BITS(IMG)) psc_device_inst (.i_core_clk(clk), .i_rst(rst), .o_loaded(d_loaded),
    .o_user_mode(d_user), .o_error(d_err), .link(link.device));
  psc_link_properties psc_link_properties_inst (.config_request_n(link.config_request_n),
    .config_serial_clock(link.config_serial_clock), .user_startup_clock(link.user_startup_clock),
    .config_enable_in_n(link.config_enable_in_n), .chain_enable_out_n(link.chain_enable_out_n),
    .status_oe_n(link.status_oe_n), .complete_oe_n(link.complete_oe_n), .status_ext_n(link.status_ext_n),
    .config_status_n(link.config_status_n));

  // core clock; the link clock comes from the host divider
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // hang guard, far above the few hundred cycles the run needs
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      conclude();
    end
  end

  // record the wire bits of each byte as the device samples them
  always @(posedge link.config_serial_clock) begin
    if (cap_left > 0) begin
      bits.push_back(link.config_data);
      cap_left--;
    end
  end

  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task conclude();
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task cmp_bit(input string name, input logic exp, input logic got);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %b seen %b", name, exp, got);
    end
  endtask

  task cmp_word(input string name, input logic [15:0] exp, input logic [15:0] got);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask

  // wired lines are set with the start so no link edge sees them early
  task begin_attempt(input logic en_n, input logic cpl, input logic sts_n);
    @(posedge clk);
    i_start <= 1'b1;
    link.config_enable_in_n <= en_n;
    link.complete_ext <= cpl;
    link.status_ext_n <= sts_n;
    @(posedge clk);
    i_start <= 1'b0;
    bits.delete();
  endtask

  // valid raised for one cycle once ready is seen high
  task send_byte(input logic [7:0] b);
    @(posedge clk);
    for (int k = 0; k < 3000 && h_ready !== 1'b1; k++) @(posedge clk);
    i_byte_valid <= 1'b1;
    i_byte <= b;
    @(posedge clk);
    i_byte_valid <= 1'b0;
    cap_left = 8;
  endtask

  task wait_wire();
    for (int k = 0; k < 3000 && cap_left != 0; k++) @(posedge clk);
    repeat (8) @(posedge clk);
  endtask

  task wait_user();
    for (int k = 0; k < 3000 && !(h_done === 1'b1 && d_user === 1'b1); k++) @(posedge clk);
  endtask

  function automatic logic [15:0] wire_word();
    logic [15:0] w;
    for (int i = 0; i < 16; i++) w[i] = bits[i];
    return w;
  endfunction

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    rst = 1'b1;
    i_start = 1'b0;
    i_byte_valid = 1'b0;
    i_byte = 8'h00;
    link.config_enable_in_n = 1'b1;
    link.status_ext_n = 1'b1;
    link.complete_ext = 1'b1;
    error_cnt = 0;
    cmp_count = 0;
    cyc = 0;
    cap_left = 0;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    // odd parity image: own fault halts the chain
    begin_attempt(1'b0, 1'b1, 1'b1);
    send_byte(8'h01);
    send_byte(8'h00);
    for (int k = 0; k < 3000 && !(h_err === 1'b1 && d_err === 1'b1); k++) @(posedge clk);
    cmp_bit("host error", 1'b1, h_err);
    cmp_bit("device error", 1'b1, d_err);
    cmp_bit("status line", 1'b0, link.config_status_n);
    cmp_bit("host done", 1'b0, h_done);
    cmp_bit("host busy", 1'b0, h_busy);
    // fresh attempt, enable tied active as in parallel loading
    begin_attempt(1'b0, 1'b1, 1'b1);
    send_byte(8'h5a);
    send_byte(8'h3c);
    wait_user();
    cmp_word("wire bits", 16'h3c5a, wire_word());
    cmp_bit("host done", 1'b1, h_done);
    cmp_bit("user mode", 1'b1, d_user);
    cmp_bit("chain out", 1'b0, link.chain_enable_out_n);
    // second in chain: predecessor image passes by, then own image
    begin_attempt(1'b1, 1'b0, 1'b1);
    send_byte(8'hff);
    send_byte(8'h00);
    wait_wire();
    cmp_bit("loaded while off", 1'b0, d_loaded);
    cmp_bit("chain while off", 1'b1, link.chain_enable_out_n);
    link.config_enable_in_n <= 1'b0;
    send_byte(8'h81);
    send_byte(8'h7e);
    wait_wire();
    repeat (40) @(posedge clk);
    cmp_bit("loaded", 1'b1, d_loaded);
    cmp_bit("user before line", 1'b0, d_user);
    cmp_bit("done before line", 1'b0, h_done);
    cmp_bit("busy before line", 1'b1, h_busy);
    link.complete_ext <= 1'b1;
    wait_user();
    cmp_bit("chain done", 1'b1, h_done);
    cmp_bit("chain user", 1'b1, d_user);
    // another device pulls status low in mid-byte
    begin_attempt(1'b0, 1'b1, 1'b1);
    send_byte(8'h55);
    repeat (5) @(posedge clk);
    link.status_ext_n <= 1'b0;
    repeat (40) @(posedge clk);
    cmp_bit("ready in halt", 1'b0, h_ready);
    cmp_bit("own status drive", 1'b1, link.status_oe_n);
    cmp_bit("loaded in halt", 1'b0, d_loaded);
    cmp_bit("user in halt", 1'b0, d_user);
    conclude();
  end
endmodule
